// >>> design/pwlc_axi_slave.sv
// AXI4-Lite slave front end that turns bus transfers into single-cycle register strobes.
`timescale 1ns/1ps
module pwlc_axi_slave (
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    input  wire pwlc_pkg::pwlc_axi_req_s  axi_req_in,
    output pwlc_pkg::pwlc_axi_rsp_s       axi_rsp_out,
    output logic                          wr_en_out,
    output logic [pwlc_pkg::ADDR_W-1:0]   wr_addr_out,
    output logic [31:0]                   wr_data_out,
    output logic [3:0]                    wr_strb_out,
    input  wire logic                     wr_err_in,
    output logic                          rd_en_out,
    output logic [pwlc_pkg::ADDR_W-1:0]   rd_addr_out,
    input  wire logic [31:0]              rd_data_in,
    input  wire logic                     rd_err_in
);
    typedef struct packed {
        logic                        aw_have;
        logic [pwlc_pkg::ADDR_W-1:0] aw_addr;
        logic                        w_have;
        logic [31:0]                 w_data;
        logic [3:0]                  w_strb;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
    } pwlc_slv_s;

    pwlc_slv_s s_r;
    pwlc_slv_s s_nxt;
    logic      aw_rdy;
    logic      w_rdy;
    logic      ar_rdy;

    // Channels stay closed while a response waits, so one write and one read are in flight at most.
    assign aw_rdy      = !s_r.aw_have && !s_r.bvalid;
    assign w_rdy       = !s_r.w_have && !s_r.bvalid;
    assign ar_rdy      = !s_r.rvalid;
    assign wr_en_out   = s_r.aw_have && s_r.w_have;
    assign wr_addr_out = s_r.aw_addr;
    assign wr_data_out = s_r.w_data;
    assign wr_strb_out = s_r.w_strb;
    assign rd_en_out   = axi_req_in.arvalid && ar_rdy;
    assign rd_addr_out = axi_req_in.araddr;

    // Responses are driven from the registered state.
    always_comb begin
        axi_rsp_out.awready = aw_rdy;
        axi_rsp_out.wready  = w_rdy;
        axi_rsp_out.bvalid  = s_r.bvalid;
        axi_rsp_out.bresp   = s_r.bresp;
        axi_rsp_out.arready = ar_rdy;
        axi_rsp_out.rvalid  = s_r.rvalid;
        axi_rsp_out.rdata   = s_r.rdata;
        axi_rsp_out.rresp   = s_r.rresp;
    end

    // Address and data are taken in either order; the write fires once both are held.
    always_comb begin
        s_nxt = s_r;
        if (axi_req_in.awvalid && aw_rdy) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && w_rdy) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = axi_req_in.wdata;
            s_nxt.w_strb = axi_req_in.wstrb;
        end
        if (wr_en_out) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = wr_err_in ? pwlc_pkg::RESP_SLVERR : pwlc_pkg::RESP_OKAY;
        end
        if (s_r.bvalid && axi_req_in.bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && axi_req_in.rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_en_out) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd_data_in;
            s_nxt.rresp  = rd_err_in ? pwlc_pkg::RESP_SLVERR : pwlc_pkg::RESP_OKAY;
        end
    end

    // Synchronous reset empties every channel.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : pwlc_axi_slave

// >>> design/pwlc_glitch_filter.sv
// Glitch filter that lets a comparator level through only after it stays put for a set number of slow ticks.
`timescale 1ns/1ps
module pwlc_glitch_filter (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       raw_in,
    input  wire logic       enable_in,
    input  wire logic [7:0] count_in,
    input  wire logic       tick_in,
    output logic            filt_out
);
    typedef struct packed {
        logic       level;
        logic [7:0] cnt;
    } pwlc_filt_s;

    pwlc_filt_s s_r;
    pwlc_filt_s s_nxt;

    assign filt_out = s_r.level;

    // A disabled filter or a zero count passes the raw level on the next edge.
    always_comb begin
        s_nxt = s_r;
        if (!enable_in || count_in == 8'h00) begin
            s_nxt.level = raw_in;
            s_nxt.cnt   = 8'h00;
        end else if (raw_in == s_r.level) begin
            s_nxt.cnt = 8'h00;
        end else if (tick_in) begin
            // Any bounce back to the old level restarts the count above.
            if (s_r.cnt + 8'h01 >= count_in) begin
                s_nxt.level = raw_in;
                s_nxt.cnt   = 8'h00;
            end else begin
                s_nxt.cnt = s_r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : pwlc_glitch_filter

// >>> design/pwlc_power_wakeup.sv
// Wake-up pin control, sticky power-down flags and brown-out reset control behind an AXI4-Lite port.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pwlc_power_wakeup (
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    input  wire logic                     por_nrst_in,
    input  wire pwlc_pkg::pwlc_axi_req_s  axi_req_in,
    output pwlc_pkg::pwlc_axi_rsp_s       axi_rsp_out,
    input  wire logic                     wake_pin_a_in,
    input  wire logic                     wake_pin_b_in,
    input  wire logic                     pd_mode_in,
    input  wire logic                     dbg_pd_mode_in,
    input  wire logic                     dbg_pd_enter_in,
    input  wire logic                     det_cmp_in,
    input  wire logic                     bo_cmp_in,
    input  wire logic                     lsi_tick_in,
    output logic                          wake_req_out,
    output logic                          det_enable_out,
    output logic [3:0]                    det_level_out,
    output logic                          bo_enable_out,
    output logic [3:0]                    bo_level_out,
    output logic                          bo_reset_out
);
    typedef struct packed {
        logic       pin_a_q;
        logic       pin_b_q;
        logic       wake_pol;
        logic       wake_a_en;
        logic       wake_b_en;
        logic       dbg_flag;
        logic       wake_flag;
        logic [1:0] wclr_pipe;
        logic       det_en;
        logic [3:0] det_lvl;
        logic       bo_key_ok;
        logic [3:0] bo_lvl;
        logic       bo_en;
        logic       bo_rst_en;
        logic       bo_fil_en;
        logic [7:0] bo_cnt;
        logic       wake_req;
        logic       bo_rst;
    } pwlc_main_s;

    // Reset picture; the brown-out fields follow the documented reset word.
    localparam pwlc_main_s RST_VAL = '{
        bo_lvl    : pwlc_pkg::BO_RESET[pwlc_pkg::BO_LVL_LSB +: 4],
        bo_en     : pwlc_pkg::BO_RESET[pwlc_pkg::BO_EN],
        bo_rst_en : pwlc_pkg::BO_RESET[pwlc_pkg::BO_RST_EN],
        bo_fil_en : pwlc_pkg::BO_RESET[pwlc_pkg::BO_FIL_EN],
        bo_cnt    : pwlc_pkg::BO_RESET[pwlc_pkg::BO_CNT_LSB +: 8],
        default   : '0
    };

    pwlc_main_s                  s_r;
    pwlc_main_s                  s_nxt;
    logic                        wr_en;
    logic [pwlc_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0]                 wr_data;
    logic [3:0]                  wr_strb;
    logic                        wr_err;
    logic                        rd_en;
    logic [pwlc_pkg::ADDR_W-1:0] rd_addr;
    logic [31:0]                 rd_data;
    logic                        rd_err;
    logic                        bo_seen;
    logic                        edge_a;
    logic                        edge_b;
    logic                        wake_evt;
    logic [31:0]                 main_wd;
    logic [31:0]                 stat_wd;
    logic [31:0]                 bo_wd;
    logic [31:0]                 main_rd;
    logic [31:0]                 stat_rd;
    logic [31:0]                 bo_rd;

    // Merges a write into the old word, one byte lane per strobe bit.
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // Picks the selected edge of a pin from its old and new level.
    function automatic logic pin_edge(input logic old_l,
                                      input logic new_l,
                                      input logic rising);
        return rising ? (new_l && !old_l) : (old_l && !new_l);
    endfunction : pin_edge

    pwlc_axi_slave u_slave (
        .clk_in      (clk_in),
        .nrst_in     (nrst_in),
        .axi_req_in  (axi_req_in),
        .axi_rsp_out (axi_rsp_out),
        .wr_en_out   (wr_en),
        .wr_addr_out (wr_addr),
        .wr_data_out (wr_data),
        .wr_strb_out (wr_strb),
        .wr_err_in   (wr_err),
        .rd_en_out   (rd_en),
        .rd_addr_out (rd_addr),
        .rd_data_in  (rd_data),
        .rd_err_in   (rd_err)
    );

    // The filter sits in the reset path, so it runs on every edge regardless of the reset enable.
    pwlc_glitch_filter u_filter (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .raw_in    (bo_cmp_in),
        .enable_in (s_r.bo_fil_en),
        .count_in  (s_r.bo_cnt),
        .tick_in   (lsi_tick_in),
        .filt_out  (bo_seen)
    );

    // Wake edges count only while the chip sits in power-down mode.
    assign edge_a   = pin_edge(s_r.pin_a_q, wake_pin_a_in, s_r.wake_pol);
    assign edge_b   = pin_edge(s_r.pin_b_q, wake_pin_b_in, s_r.wake_pol);
    assign wake_evt = pd_mode_in && ((s_r.wake_a_en && edge_a) || (s_r.wake_b_en && edge_b));

    // Words as a write would leave them, byte lanes applied.
    assign main_wd = lane_merge(main_rd, wr_data, wr_strb);
    assign stat_wd = lane_merge(stat_rd, wr_data, wr_strb);
    assign bo_wd   = lane_merge(bo_rd, wr_data, wr_strb);

    // Read views; clear bits and the key byte always read as zero.
    always_comb begin
        main_rd = '0;
        main_rd[pwlc_pkg::MAIN_LVL_LSB +: 4] = s_r.det_lvl;
        main_rd[pwlc_pkg::MAIN_DET_EN]       = s_r.det_en;
        stat_rd = '0;
        stat_rd[pwlc_pkg::ST_POL]       = s_r.wake_pol;
        stat_rd[pwlc_pkg::ST_B_EN]      = s_r.wake_b_en;
        stat_rd[pwlc_pkg::ST_A_EN]      = s_r.wake_a_en;
        stat_rd[pwlc_pkg::ST_DET_OUT]   = s_r.det_en && det_cmp_in;
        stat_rd[pwlc_pkg::ST_DBG_FLAG]  = s_r.dbg_flag;
        stat_rd[pwlc_pkg::ST_WAKE_FLAG] = s_r.wake_flag;
        bo_rd = '0;
        bo_rd[pwlc_pkg::BO_OUT]           = s_r.bo_en && bo_seen;
        bo_rd[pwlc_pkg::BO_LVL_LSB +: 4]  = s_r.bo_lvl;
        bo_rd[pwlc_pkg::BO_EN]            = s_r.bo_en;
        bo_rd[pwlc_pkg::BO_RST_EN]        = s_r.bo_rst_en;
        bo_rd[pwlc_pkg::BO_FIL_EN]        = s_r.bo_fil_en;
        bo_rd[pwlc_pkg::BO_CNT_LSB +: 8]  = s_r.bo_cnt;
    end

    // Read decode; an unmapped address answers with an error and zero data.
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        if (rd_addr == pwlc_pkg::OFF_MAIN) begin
            rd_data = main_rd;
        end else if (rd_addr == pwlc_pkg::OFF_STATUS) begin
            rd_data = stat_rd;
        end else if (rd_addr == pwlc_pkg::OFF_BROWNOUT) begin
            rd_data = bo_rd;
        end else begin
            rd_err = 1'b1;
        end
    end

    assign wr_err = wr_addr != pwlc_pkg::OFF_MAIN && wr_addr != pwlc_pkg::OFF_STATUS
                    && wr_addr != pwlc_pkg::OFF_BROWNOUT;

    // Next-state logic for registers, flags and the brown-out reset.
    always_comb begin
        s_nxt           = s_r;
        s_nxt.pin_a_q   = wake_pin_a_in;
        s_nxt.pin_b_q   = wake_pin_b_in;
        s_nxt.wake_req  = wake_evt;
        s_nxt.wclr_pipe = {s_r.wclr_pipe[0], 1'b0};

        // Register writes.
        if (wr_en && wr_addr == pwlc_pkg::OFF_MAIN) begin
            s_nxt.det_lvl      = main_wd[pwlc_pkg::MAIN_LVL_LSB +: 4];
            s_nxt.det_en       = main_wd[pwlc_pkg::MAIN_DET_EN];
            s_nxt.wclr_pipe[0] = wr_strb[0] && wr_data[pwlc_pkg::MAIN_WAKE_CLR];
            if (wr_strb[0] && wr_data[pwlc_pkg::MAIN_DBG_CLR]) begin
                s_nxt.dbg_flag = 1'b0;
            end
        end else if (wr_en && wr_addr == pwlc_pkg::OFF_STATUS) begin
            // Software should drop both enables before flipping the edge polarity.
            s_nxt.wake_pol  = stat_wd[pwlc_pkg::ST_POL];
            s_nxt.wake_b_en = stat_wd[pwlc_pkg::ST_B_EN];
            s_nxt.wake_a_en = stat_wd[pwlc_pkg::ST_A_EN];
        end else if (wr_en && wr_addr == pwlc_pkg::OFF_BROWNOUT) begin
            // A key write only unlocks; any other write lands only when unlocked, then relocks.
            if (wr_strb == 4'hf && wr_data == pwlc_pkg::BO_UNLOCK_KEY) begin
                s_nxt.bo_key_ok = 1'b1;
            end else begin
                s_nxt.bo_key_ok = 1'b0;
                if (s_r.bo_key_ok) begin
                    s_nxt.bo_lvl    = bo_wd[pwlc_pkg::BO_LVL_LSB +: 4];
                    s_nxt.bo_en     = bo_wd[pwlc_pkg::BO_EN];
                    s_nxt.bo_rst_en = bo_wd[pwlc_pkg::BO_RST_EN];
                    s_nxt.bo_fil_en = bo_wd[pwlc_pkg::BO_FIL_EN];
                    s_nxt.bo_cnt    = bo_wd[pwlc_pkg::BO_CNT_LSB +: 8];
                end
            end
        end

        // Delayed wake flag clear; setting below still wins in the same cycle.
        if (s_r.wclr_pipe[pwlc_pkg::WAKE_CLR_CYC-1]) begin
            s_nxt.wake_flag = 1'b0;
        end

        // Hardware sets beat software clears so no event is lost.
        if (dbg_pd_enter_in) begin
            s_nxt.dbg_flag = 1'b1;
        end
        if (wake_evt && dbg_pd_mode_in) begin
            s_nxt.wake_flag = 1'b1;
        end

        // Reset request follows the filtered or raw comparator per the filter setting.
        s_nxt.bo_rst = s_r.bo_en && s_r.bo_rst_en && bo_seen;
    end

    // The power-on reset loads the reset picture into every field; a system reset spares the wake enables and both flags.
    always_ff @(posedge clk_in) begin
        if (!por_nrst_in) begin
            s_r <= RST_VAL;
        end else if (!nrst_in) begin
            s_r           <= RST_VAL;
            s_r.wake_a_en <= s_r.wake_a_en;
            s_r.wake_b_en <= s_r.wake_b_en;
            s_r.dbg_flag  <= s_r.dbg_flag;
            s_r.wake_flag <= s_r.wake_flag;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Controls for the analog comparators come straight from the registers.
    assign wake_req_out   = s_r.wake_req;
    assign det_enable_out = s_r.det_en;
    assign det_level_out  = s_r.det_lvl;
    assign bo_enable_out  = s_r.bo_en;
    assign bo_level_out   = s_r.bo_lvl;
    assign bo_reset_out   = s_r.bo_rst;
endmodule : pwlc_power_wakeup

// >>> pkg/pwlc_pkg.sv
// Constants, bus carriers and register layout of the wake-up and brown-out control block.
package pwlc_pkg;
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFF_MAIN      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_BROWNOUT  = 8'h08;
    // Main power control fields.
    localparam int          MAIN_LVL_LSB  = 5;
    localparam int          MAIN_DET_EN   = 4;
    localparam int          MAIN_DBG_CLR  = 3;
    localparam int          MAIN_WAKE_CLR = 2;
    // Status and wake-up fields.
    localparam int          ST_POL        = 10;
    localparam int          ST_B_EN       = 9;
    localparam int          ST_A_EN       = 8;
    localparam int          ST_DET_OUT    = 2;
    localparam int          ST_DBG_FLAG   = 1;
    localparam int          ST_WAKE_FLAG  = 0;
    // Brown-out control fields.
    localparam int          BO_OUT        = 15;
    localparam int          BO_LVL_LSB    = 11;
    localparam int          BO_EN         = 10;
    localparam int          BO_RST_EN     = 9;
    localparam int          BO_FIL_EN     = 8;
    localparam int          BO_CNT_LSB    = 0;
    localparam logic [31:0] BO_RESET      = 32'h0000_0400;
    localparam logic [31:0] BO_UNLOCK_KEY = 32'ha500_0000;
    // Cycles from a wake flag clear write to the flag dropping.
    localparam int          WAKE_CLR_CYC  = 2;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } pwlc_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pwlc_axi_rsp_s;
endpackage : pwlc_pkg

// >>> verification/pwlc_power_wakeup_properties.sv
// Concurrent checks on the bus handshake, reset state and wake pulses of the block.
`timescale 1ns/1ps
module pwlc_wake_props (
    input wire logic                    clk_in,
    input wire logic                    nrst_in,
    input wire logic                    por_nrst_in,
    input wire pwlc_pkg::pwlc_axi_req_s axi_req_in,
    input wire pwlc_pkg::pwlc_axi_rsp_s axi_rsp_out,
    input wire logic                    pd_mode_in,
    input wire logic                    wake_req_out,
    input wire logic                    bo_enable_out,
    input wire logic                    bo_reset_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in || !por_nrst_in);
    // Address and data offered together, as the bench always does.
    sequence s_wr_taken;
        axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid && axi_rsp_out.wready;
    endsequence
    sequence s_resp;
        !axi_rsp_out.bvalid ##1 axi_rsp_out.bvalid;
    endsequence
    property p_wr_lat; s_wr_taken |=> s_resp; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write response not two edges after take");
    property p_b_drop; axi_rsp_out.bvalid && axi_req_in.bready |=> !axi_rsp_out.bvalid; endproperty
    a_b_drop: assert property (p_b_drop) else $error("write response held after acceptance");
    property p_r_drop; axi_rsp_out.rvalid && axi_req_in.rready |=> !axi_rsp_out.rvalid; endproperty
    a_r_drop: assert property (p_r_drop) else $error("read response held after acceptance");
    property p_ar; axi_req_in.arvalid && axi_rsp_out.arready |=> axi_rsp_out.rvalid; endproperty
    a_ar: assert property (p_ar) else $error("read answer not one edge after take");
    // An address past the last register must answer with an error and zero data.
    property p_err;
        axi_req_in.arvalid && axi_rsp_out.arready && axi_req_in.araddr > 8'h08
        |=> axi_rsp_out.rresp == pwlc_pkg::RESP_SLVERR && axi_rsp_out.rdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("unmapped read not refused");
    property p_busy; axi_rsp_out.bvalid |-> !axi_rsp_out.awready && !axi_rsp_out.wready; endproperty
    a_busy: assert property (p_busy) else $error("write accepted while response pending");
    // A wake pulse lasts one cycle and only follows power-down mode.
    property p_wake; wake_req_out |-> ($past(pd_mode_in) || $past(pd_mode_in, 2)) ##1 !wake_req_out; endproperty
    a_wake: assert property (p_wake) else $error("wake pulse outside power-down");
    property p_rst; $rose(por_nrst_in) |-> bo_enable_out && !bo_reset_out && !wake_req_out; endproperty
    a_rst: assert property (p_rst) else $error("wrong output state after power-on reset");
endmodule : pwlc_wake_props

bind pwlc_power_wakeup pwlc_wake_props i_props (.clk_in(clk_in), .nrst_in(nrst_in), .por_nrst_in(por_nrst_in),
    .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out), .pd_mode_in(pd_mode_in), .wake_req_out(wake_req_out),
    .bo_enable_out(bo_enable_out), .bo_reset_out(bo_reset_out));

// >>> verification/pwlc_power_wakeup_test.sv
// Self-checking bench for the wake-up flags and brown-out control block.
`timescale 1ns/1ps
module pwlc_power_wakeup_test;
    logic                    clk_in, nrst_in, por_nrst_in, pin_a, pin_b, pdm, dbgm, dbg_ent, det_cmp, bo_cmp, tick;
    logic                    wake, det_en, bo_en, bo_rst;
    logic [3:0]              det_lvl, bo_lvl;
    logic [31:0]             d, v;
    logic [1:0]              resp;
    pwlc_pkg::pwlc_axi_req_s q;
    pwlc_pkg::pwlc_axi_rsp_s r;
    int                      fail_count = 0, n_compared = 0, wk = 0, tc = 0, seed = 32'hbe73;

    pwlc_power_wakeup i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .por_nrst_in(por_nrst_in), .axi_req_in(q),
        .axi_rsp_out(r), .wake_pin_a_in(pin_a), .wake_pin_b_in(pin_b), .pd_mode_in(pdm), .dbg_pd_mode_in(dbgm),
        .dbg_pd_enter_in(dbg_ent), .det_cmp_in(det_cmp), .bo_cmp_in(bo_cmp), .lsi_tick_in(tick),
        .wake_req_out(wake), .det_enable_out(det_en), .det_level_out(det_lvl), .bo_enable_out(bo_en),
        .bo_level_out(bo_lvl), .bo_reset_out(bo_rst));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Slow oscillator tick every fourth cycle; wake pulses are counted as they come.
    always @(posedge clk_in) begin
        tc <= tc + 1;
        tick <= (tc % 4 == 3);
        if (wake === 1'b1) wk <= wk + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc
    // Both write channels are offered at once with full lanes, since the key needs every strobe set.
    // Each channel is released at the edge that takes it, so a slave that takes them apart still works.
    task automatic wr(input logic [7:0] a, input logic [31:0] dd);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        q.awvalid <= 1'b1;
        q.awaddr <= a;
        q.wvalid <= 1'b1;
        q.wdata <= dd;
        q.wstrb <= 4'hf;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_in);
            if (!aw_ok && r.awready) begin
                aw_ok = 1'b1;
                q.awvalid <= 1'b0;
            end
            if (!w_ok && r.wready) begin
                w_ok = 1'b1;
                q.wvalid <= 1'b0;
            end
        end
        do @(posedge clk_in); while (!r.bvalid);
        resp = r.bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        q.arvalid <= 1'b1;
        q.araddr <= a;
        do @(posedge clk_in); while (!r.arready);
        q.arvalid <= 1'b0;
        do @(posedge clk_in); while (!r.rvalid);
        d = r.rdata;
        resp = r.rresp;
    endtask : rd
    task automatic rst(input logic por);
        nrst_in <= 1'b0;
        por_nrst_in <= ~por;
        cyc(4);
        nrst_in <= 1'b1;
        por_nrst_in <= 1'b1;
        cyc(1);
    endtask : rst
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    // The limit is far above the few hundred cycles the sequence needs.
    initial begin
        #300000;
        fail_count++;
        print_verdict();
    end

    initial begin
        {nrst_in, por_nrst_in, pin_a, pin_b, pdm, dbgm, dbg_ent, det_cmp, bo_cmp} = '0;
        q = '0;
        q.bready = 1'b1;
        q.rready = 1'b1;
        cyc(4);
        nrst_in <= 1'b1;
        por_nrst_in <= 1'b1;
        cyc(1);
        rd(8'h08); chk(d, pwlc_pkg::BO_RESET);
        rd(8'h04); chk(d, 32'h0);
        rd(8'h00); chk(d, 32'h0);
        rd(8'h0c); chk({d[31:2], resp}, 32'h2);
        wr(8'h10, 32'h1); chk(32'(resp), 32'h2);
        // A write without the key is dropped; a keyed write lands and relocks.
        wr(8'h08, 32'h1ff); rd(8'h08); chk(d, pwlc_pkg::BO_RESET);
        v = $random(seed) & 32'h7dff;
        wr(8'h08, pwlc_pkg::BO_UNLOCK_KEY); wr(8'h08, v); rd(8'h08); chk(d, v);
        chk(32'({bo_lvl, bo_en}), 32'(v[14:10]));
        wr(8'h08, 32'h0); rd(8'h08); chk(d, v);
        // A short glitch is swallowed by a three-tick filter; a long level raises reset.
        wr(8'h08, pwlc_pkg::BO_UNLOCK_KEY); wr(8'h08, 32'h0703);
        bo_cmp <= 1'b1; cyc(6); bo_cmp <= 1'b0; cyc(20); chk(32'(bo_rst), 32'h0);
        bo_cmp <= 1'b1; cyc(20); chk(32'(bo_rst), 32'h1);
        rd(8'h08); chk(d, 32'h8703);
        wr(8'h08, pwlc_pkg::BO_UNLOCK_KEY); wr(8'h08, 32'h0500); cyc(3); chk(32'(bo_rst), 32'h0);
        bo_cmp <= 1'b0;
        // Rising polarity with only pin A enabled: one wake, none from a fall or from pin B.
        wr(8'h04, 32'h500); pdm <= 1'b1; dbgm <= 1'b1;
        cyc(2); pin_a <= 1'b1; cyc(4); chk(32'(wk), 32'h1);
        pin_a <= 1'b0; cyc(4); pin_b <= 1'b1; cyc(4); pin_b <= 1'b0; cyc(4); chk(32'(wk), 32'h1);
        rd(8'h04); chk(d, 32'h501);
        dbg_ent <= 1'b1; cyc(1); dbg_ent <= 1'b0; pdm <= 1'b0; dbgm <= 1'b0;
        rd(8'h04); chk(d, 32'h503);
        rst(1'b0); rd(8'h04); chk(d, 32'h103);
        rd(8'h08); chk(d, pwlc_pkg::BO_RESET);
        wr(8'h00, 32'h8); rd(8'h04); chk(d, 32'h101);
        // The wake flag drops two cycles after the clear lands, so the read waits that long.
        wr(8'h00, 32'h4); cyc(pwlc_pkg::WAKE_CLR_CYC); rd(8'h04); chk(d, 32'h100);
        rd(8'h00); chk(d, 32'h0);
        det_cmp <= 1'b1; rd(8'h04); chk(d, 32'h100);
        wr(8'h00, 32'h1f0); rd(8'h04); chk(d, 32'h104);
        rd(8'h00); chk(d, 32'h1f0); chk(32'({det_lvl, det_en}), 32'h1f);
        // Falling polarity with only pin B enabled: a rise does nothing, the fall wakes without setting the flag.
        wr(8'h04, 32'h200); pdm <= 1'b1; pin_b <= 1'b1; cyc(4); chk(32'(wk), 32'h1);
        pin_b <= 1'b0; cyc(4); chk(32'(wk), 32'h2);
        pdm <= 1'b0; rd(8'h04); chk(d, 32'h204);
        rst(1'b1); rd(8'h04); chk(d, 32'h0);
        print_verdict();
    end
endmodule : pwlc_power_wakeup_test
